// File: swd_pkg.sv
package swd_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0] SWD_OFF_MODE = 4'h0;     // wake_request_mode_control_d
    localparam logic [3:0] SWD_OFF_CLEAR = 4'h4;    // interrupt_request_clear_reg
    localparam logic [3:0] SWD_OFF_STATUS = 4'h8;   // sticky event status
    localparam logic [3:0] SWD_OFF_MASK = 4'hC;     // event mask

    // ----------------------------------------------------------------
    // field layout: source n occupies byte n, lane base = 8*n
    // ----------------------------------------------------------------
    localparam int SWD_NSRC = 4;
    localparam int SWD_POS_EN = 0;
    localparam int SWD_POS_ST = 2;
    localparam int SWD_POS_MODE = 4;
    localparam int SWD_SRC_RMC = 3;
    localparam int SWD_SRC_RTC = 2;
    localparam int SWD_SRC_EXTD = 1;
    localparam int SWD_SRC_USB = 0;

    // ----------------------------------------------------------------
    // reset values and codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SWD_MODE_RST = 3'h2;
    localparam logic [2:0] SWD_MODE_LOW = 3'h0;
    localparam logic [2:0] SWD_MODE_HIGH = 3'h1;
    localparam logic [2:0] SWD_MODE_FALL = 3'h2;
    localparam logic [2:0] SWD_MODE_RISE = 3'h3;
    localparam logic [2:0] SWD_MODE_BOTH = 3'h4;
    localparam logic [1:0] SWD_ST_NONE = 2'h0;
    localparam logic [1:0] SWD_ST_RISE = 2'h1;
    localparam logic [1:0] SWD_ST_FALL = 2'h2;
    localparam logic [1:0] SWD_ST_BOTH = 2'h3;

endpackage

// File: swd_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for the request pins
module swd_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } swd_sync_s;

    swd_sync_s s_q;
    swd_sync_s s_d;

    // refuse a width that the synchroniser cannot serve, at elaboration
    if (WIDTH < 1)
    begin : g_bad_width
        $error("swd_sync: WIDTH must be at least 1");
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d.meta = async_in;
        s_d.sync = s_q.meta;
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.sync;
endmodule // swd_sync

// File: swd_detect.sv
`timescale 1ns/1ps
// per-source level/edge detector; pure combinational decode on a previous sample
module swd_detect (
    input wire logic [2:0] mode,
    input wire logic cur,
    input wire logic prev,
    output logic hit,
    output logic [1:0] edge_kind
);
    import swd_pkg::*;

    logic rise;
    logic fall;

    // edge and level match for the selected mode
    always_comb
    begin
        rise = cur & ~prev;
        fall = ~cur & prev;
        hit = 1'b0;
        edge_kind = SWD_ST_NONE;
        case (mode)
            SWD_MODE_LOW: hit = ~cur;
            SWD_MODE_HIGH: hit = cur;
            SWD_MODE_FALL: hit = fall;
            SWD_MODE_RISE: hit = rise;
            SWD_MODE_BOTH:
            begin
                hit = rise | fall;
                edge_kind = rise ? SWD_ST_RISE : (fall ? SWD_ST_FALL : SWD_ST_NONE);
            end
            default: hit = 1'b0; // prohibited codes never match
        endcase
    end
endmodule // swd_detect

// File: swd_wake_ctrl.sv
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - bits 27-26 report remote receiver detected edge: none, rise, fall, both.
// - bits 19-18 report clock calendar detected edge, same coding.
// - input D mode bits 14-12 select low, high, fall, rise or both.
// - bits 11-10 report input D detected edge.
// - USB resume mode bits 6-4 select low, high, fall, rise or both.
// - bits 3-2 report USB resume detected edge.
// - edge status is meaningful only in both-edge mode.
// - in both-edge mode status tells which edge caused the wake.
// - clearing a source request through the clear register clears its status.
module swd_wake_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    input wire logic remote_rx_wake_request,
    input wire logic clock_calendar_wake_request,
    input wire logic ext_input_d_wake_request,
    input wire logic usb_resume_wake_request,
    output logic [3:0] wake_req,
    output logic standby_release,
    output logic irq
);
    import swd_pkg::*;

    typedef struct packed {
        logic [3:0][2:0] mode;
        logic [3:0][1:0] st;
        logic [3:0] en;
        logic [3:0] prev;
        logic [3:0] pend;
        logic [3:0] mask;
        logic [3:0] wake;
        logic rel;
        logic irq;
        logic [31:0] rdata;
    } swd_state_s;

    swd_state_s s_q;
    swd_state_s s_d;
    logic [3:0] req_sync;
    logic [3:0] hit;
    logic [3:0][1:0] kind;
    logic [3:0] clr;

    // pack the mode control word from the per-source fields
    function automatic logic [31:0] swd_pack_mode(input swd_state_s s);
        logic [31:0] w;
        w = '0;
        for (int n = 0; n < SWD_NSRC; n++)
        begin
            w[8*n+SWD_POS_MODE +: 3] = s.mode[n];
            w[8*n+SWD_POS_ST +: 2] = s.st[n];
            w[8*n+SWD_POS_EN] = s.en[n];
        end
        return w;
    endfunction

    // ----------------------------------------------------------------
    // input synchronisation and detection
    // ----------------------------------------------------------------
    swd_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({remote_rx_wake_request, clock_calendar_wake_request,
                   ext_input_d_wake_request, usb_resume_wake_request}),
        .sync_out(req_sync)
    );

    // one detector per source
    for (genvar g = 0; g < SWD_NSRC; g++)
    begin : g_det
        swd_detect u_det (
            .mode(s_q.mode[g]),
            .cur(req_sync[g]),
            .prev(s_q.prev[g]),
            .hit(hit[g]),
            .edge_kind(kind[g])
        );
    end

    // clear register decode: one source per written code, reserved codes ignored
    always_comb
    begin
        clr = '0;
        if (wr_stb && addr == SWD_OFF_CLEAR && wdata[4:2] == 3'h0)
        begin
            clr[wdata[1:0]] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.prev = req_sync;
        // mode word write; reserved and status bits are not stored
        if (wr_stb && addr == SWD_OFF_MODE)
        begin
            for (int n = 0; n < SWD_NSRC; n++)
            begin
                s_d.mode[n] = wdata[8*n+SWD_POS_MODE +: 3];
                s_d.en[n] = wdata[8*n+SWD_POS_EN];
            end
        end
        if (wr_stb && addr == SWD_OFF_MASK)
        begin
            s_d.mask = wdata[3:0];
        end
        // requests: clear loses to a new hit in the same cycle
        for (int n = 0; n < SWD_NSRC; n++)
        begin
            if (clr[n])
            begin
                s_d.st[n] = SWD_ST_NONE;
                s_d.pend[n] = 1'b0;
            end
            if (hit[n] && s_q.en[n])
            begin
                s_d.pend[n] = 1'b1;
                if (s_q.mode[n] == SWD_MODE_BOTH)
                begin
                    s_d.st[n] = s_q.st[n] | kind[n];
                end
            end
        end
        // write-one-to-clear on the sticky status copy is the same pend bits
        if (wr_stb && addr == SWD_OFF_STATUS)
        begin
            for (int n = 0; n < SWD_NSRC; n++)
            begin
                if (wdata[n] && !(hit[n] && s_q.en[n]))
                begin
                    s_d.pend[n] = 1'b0;
                end
            end
        end
        s_d.wake = s_d.pend;
        s_d.rel = |s_d.pend;
        s_d.irq = |(s_d.pend & s_d.mask);
        // read data stands one cycle after the strobe
        s_d.rdata = '0;
        if (rd_stb)
        begin
            case (addr)
                SWD_OFF_MODE: s_d.rdata = swd_pack_mode(s_q);
                SWD_OFF_STATUS: s_d.rdata = {28'h0000000, s_q.pend};
                SWD_OFF_MASK: s_d.rdata = {28'h0000000, s_q.mask};
                default: s_d.rdata = '0;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            for (int n = 0; n < SWD_NSRC; n++)
            begin
                s_q.mode[n] <= SWD_MODE_RST;
            end
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign wake_req = s_q.wake;
    assign standby_release = s_q.rel;
    assign irq = s_q.irq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_status_needs_both: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st[0] != 2'h0) |-> (s_q.mode[0] == SWD_MODE_BOTH || $past(s_q.mode[0]) == SWD_MODE_BOTH
        || $past(s_q.st[0]) != 2'h0))
        else $error("usb status set outside both-edge mode");
    a_rise_recorded: assert property (@(posedge clk) disable iff (!rst_n)
        (hit[1] && s_q.en[1] && s_q.mode[1] == SWD_MODE_BOTH && req_sync[1]) |=> s_q.st[1][0])
        else $error("input d rising edge not recorded");
    a_clear_status: assert property (@(posedge clk) disable iff (!rst_n)
        (clr[2] && !hit[2]) |=> (s_q.st[2] == 2'h0 && !s_q.pend[2]))
        else $error("clock calendar status not cleared");
    a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (!s_q.en[3] && !s_q.pend[3] && !clr[3]) |=> !s_q.pend[3])
        else $error("disabled remote request latched");
    a_enable_hit: assert property (@(posedge clk) disable iff (!rst_n)
        (hit[0] && s_q.en[0]) |=> wake_req[0])
        else $error("enabled usb wake not forwarded");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rd_stb) && $past(addr) == SWD_OFF_MODE |-> (rdata[31] == 1'b0 && rdata[23] == 1'b0
        && rdata[15] == 1'b0 && rdata[7] == 1'b0 && rdata[25] == 1'b0 && rdata[17] == 1'b0
        && rdata[9] == 1'b0 && rdata[1] == 1'b0))
        else $error("reserved mode bits read nonzero");
    a_status_field: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rd_stb) && $past(addr) == SWD_OFF_MODE |-> rdata[27:26] == $past(s_q.st[3]))
        else $error("remote edge status misplaced");
    a_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
        irq == |(wake_req & s_q.mask))
        else $error("irq does not follow unmasked status");
    a_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stb && addr == SWD_OFF_MODE) |=> s_q.mode[1] == $past(wdata[14:12]))
        else $error("input d mode not stored");

    // ----------------------------------------------------------------
    // read port and edge status placement
    // ----------------------------------------------------------------
    // read data stands one cycle, then returns to zero
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(rd_stb) |-> rdata == 32'h00000000)
        else $error("read data outside its cycle");
    // calendar detected edge sits in bits 19-18
    a_calendar_field: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rd_stb) && $past(addr) == SWD_OFF_MODE |-> rdata[19:18] == $past(s_q.st[2]))
        else $error("calendar edge status misplaced");
    // input d detected edge sits in bits 11-10
    a_input_d_field: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rd_stb) && $past(addr) == SWD_OFF_MODE |-> rdata[11:10] == $past(s_q.st[1]))
        else $error("input d edge status misplaced");
    // usb resume detected edge sits in bits 3-2
    a_usb_field: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rd_stb) && $past(addr) == SWD_OFF_MODE |-> rdata[3:2] == $past(s_q.st[0]))
        else $error("usb edge status misplaced");

    // ----------------------------------------------------------------
    // detection and status
    // ----------------------------------------------------------------
    // both-edge mode: a falling edge lands in the upper status bit
    a_fall_recorded: assert property (@(posedge clk) disable iff (!rst_n)
        (hit[0] && s_q.en[0] && s_q.mode[0] == SWD_MODE_BOTH && !req_sync[0]) |=> s_q.st[0][1])
        else $error("usb falling edge not recorded");
    // status only grows while the source sits in both-edge mode
    a_status_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.st[1] != 2'h0 && s_q.st[1] != $past(s_q.st[1])) |-> $past(s_q.mode[1]) == SWD_MODE_BOTH)
        else $error("input d status set outside both-edge mode");
    // clear register wipes input d status and request
    a_clear_input_d: assert property (@(posedge clk) disable iff (!rst_n)
        (clr[1] && !hit[1]) |=> (s_q.st[1] == SWD_ST_NONE && !s_q.pend[1]))
        else $error("input d status not cleared");
    // clear register wipes usb status and request
    a_clear_usb: assert property (@(posedge clk) disable iff (!rst_n)
        (clr[0] && !hit[0]) |=> (s_q.st[0] == SWD_ST_NONE && !s_q.pend[0]))
        else $error("usb status not cleared");
    // a clear register write leaves the mode word alone
    a_clear_keeps_mode: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stb && addr == SWD_OFF_CLEAR) |=> ($stable(s_q.mode) && $stable(s_q.en)))
        else $error("clear write disturbed mode word");

    // ----------------------------------------------------------------
    // requests, registers and outputs
    // ----------------------------------------------------------------
    // write-one-to-clear on the status copy drops the request
    a_status_w1c: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stb && addr == SWD_OFF_STATUS && wdata[3] && !hit[3]) |=> !s_q.pend[3])
        else $error("remote status not cleared by write");
    // a pending request holds until software clears it
    a_pend_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (s_q.pend[1] && !clr[1] && !(wr_stb && addr == SWD_OFF_STATUS && wdata[1])) |=> s_q.pend[1])
        else $error("input d request dropped by itself");
    // release output is the or of all pending requests
    a_release_any: assert property (@(posedge clk) disable iff (!rst_n)
        standby_release == |wake_req)
        else $error("standby release does not follow requests");
    // mask register keeps the written low nibble
    a_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stb && addr == SWD_OFF_MASK) |=> s_q.mask == $past(wdata[3:0]))
        else $error("mask not stored");
    // calendar enable follows the mode word write
    a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stb && addr == SWD_OFF_MODE) |=> s_q.en[2] == $past(wdata[16]))
        else $error("calendar enable not stored");
    // usb resume mode follows the mode word write
    a_usb_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_stb && addr == SWD_OFF_MODE) |=> s_q.mode[0] == $past(wdata[6:4]))
        else $error("usb mode not stored");

    // ----------------------------------------------------------------
    // coverage of the main scenarios
    // ----------------------------------------------------------------
    c_both_wake: cover property (@(posedge clk) disable iff (!rst_n) s_q.st[1] == SWD_ST_BOTH);
    c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
    c_clear: cover property (@(posedge clk) disable iff (!rst_n) clr[0] && s_q.pend[0]);
    c_level_wake: cover property (@(posedge clk) disable iff (!rst_n)
        hit[1] && s_q.en[1] && s_q.mode[1] == SWD_MODE_LOW);
    c_status_w1c: cover property (@(posedge clk) disable iff (!rst_n)
        wr_stb && addr == SWD_OFF_STATUS && s_q.pend[3]);
endmodule // swd_wake_ctrl

// File: swd_wake_ctrl_tb.sv
`timescale 1ns/1ps
module swd_wake_ctrl_tb;
    import swd_pkg::*;

    // ----------------------------------------------------------------
    // signals and step table
    // ----------------------------------------------------------------
    logic clk, rst_n, wr_stb, rd_stb, standby_release, irq;
    logic [3:0] addr, pins, wake_req;
    logic [31:0] wdata, rdata, rv;
    int failures, n_compared, i;
    logic [2:0] md_tab [6] = '{SWD_MODE_LOW, SWD_MODE_HIGH, SWD_MODE_FALL, SWD_MODE_RISE, SWD_MODE_BOTH, SWD_MODE_BOTH};
    logic lv_tab [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [1:0] st_tab [6] = '{SWD_ST_NONE, SWD_ST_NONE, SWD_ST_NONE, SWD_ST_NONE, SWD_ST_FALL, SWD_ST_RISE};

    swd_wake_ctrl u_swd_wake_ctrl (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .remote_rx_wake_request(pins[3]), .clock_calendar_wake_request(pins[2]),
        .ext_input_d_wake_request(pins[1]), .usb_resume_wake_request(pins[0]), .wake_req(wake_req),
        .standby_release(standby_release), .irq(irq));

    // ----------------------------------------------------------------
    // clock and bus tasks
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    // read data is sampled in the single cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic final_report();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // mode first, enable later, drive pin, check wake and status, then clear
    task automatic wake_case(input int s, input logic [2:0] md, input logic lv, input logic [1:0] st, input logic cs);
        logic [31:0] mw, r;
        logic seen;
        int k;
        mw = 32'h30202020;
        mw[8*s+SWD_POS_MODE +: 3] = md;
        wr(SWD_OFF_MODE, mw);
        mw[8*s+SWD_POS_EN] = 1'b1;
        wr(SWD_OFF_MODE, mw);
        pins[s] <= lv;
        seen = 1'b0;
        for (k = 0; k < 12 && !seen; k++)
        begin
            @(posedge clk);
            #1 seen = (wake_req[s] === 1'b1);
        end
        chk("wake_req", 32'h1, {31'h0, seen});
        chk("standby_release", 32'h1, {31'h0, standby_release});
        chk("irq", 32'h1, {31'h0, irq});
        rd(SWD_OFF_MODE, r);
        chk("mode_field", {29'h0, md}, {29'h0, r[8*s+SWD_POS_MODE +: 3]});
        if (cs)
            chk("edge_status", {30'h0, st}, {30'h0, r[8*s+SWD_POS_ST +: 2]});
        mw[8*s+SWD_POS_EN] = 1'b0;
        wr(SWD_OFF_MODE, mw);
        wr(SWD_OFF_CLEAR, 32'(s));
        cycles(3);
        chk("wake_req_cleared", 32'h0, {31'h0, wake_req[s]});
        rd(SWD_OFF_MODE, r);
        chk("status_cleared", 32'h0, {30'h0, r[8*s+SWD_POS_ST +: 2]});
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        failures = 0;
        n_compared = 0;
        rst_n = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        pins = 4'h4;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(SWD_OFF_MODE, rv);
        chk("mode_reset", 32'h20202020, rv);
        rd(SWD_OFF_STATUS, rv);
        chk("status_reset", 32'h0, rv);
        // reserved and read-only bits keep their values
        wr(SWD_OFF_MODE, 32'hBEAEAEAE);
        rd(SWD_OFF_MODE, rv);
        chk("mode_reserved_bits", 32'h30202020, rv);
        wr(SWD_OFF_MODE, 32'h30202020);
        wr(4'h2, 32'hFFFFFFFF);
        rd(4'h1, rv);
        chk("unmapped_read", 32'h0, rv);
        rd(SWD_OFF_MODE, rv);
        chk("mode_after_unmapped", 32'h30202020, rv);
        // remote receiver, masked then unmasked, status write-one-to-clear
        wr(SWD_OFF_MODE, 32'h30202020);
        wr(SWD_OFF_MODE, 32'h31202020);
        pins[3] <= 1'b1;
        cycles(8);
        chk("remote_wake", 32'h1, {31'h0, wake_req[3]});
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd(SWD_OFF_STATUS, rv);
        chk("status_remote", 32'h8, rv & 32'hF);
        wr(SWD_OFF_MASK, 32'h8);
        cycles(2);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        wr(SWD_OFF_MODE, 32'h30202020);
        wr(SWD_OFF_STATUS, 32'h8);
        cycles(3);
        chk("remote_cleared", 32'h0, {30'h0, wake_req[3], irq});
        wr(SWD_OFF_MASK, 32'hF);
        // calendar on its falling edge, then each of the five modes on input D and USB
        wake_case(SWD_SRC_RTC, SWD_MODE_FALL, 1'b0, SWD_ST_NONE, 1'b0);
        for (i = 0; i < 6; i++)
        begin
            wake_case(SWD_SRC_EXTD, md_tab[i], lv_tab[i], st_tab[i], 1'b1);
            wake_case(SWD_SRC_USB, md_tab[i], lv_tab[i], st_tab[i], 1'b1);
        end
        // rising edge on a falling-edge USB source and disabled input D never wake
        pins[1:0] <= 2'b00;
        cycles(8);
        wr(SWD_OFF_MODE, 32'h30203020);
        wr(SWD_OFF_MODE, 32'h30203021);
        pins[1:0] <= 2'b11;
        cycles(8);
        chk("no_wake", 32'h0, {28'h0, wake_req});
        final_report();
    end

    initial
    begin
        #2000000;
        failures++;
        final_report();
    end
endmodule // swd_wake_ctrl_tb
